// ==== dv/fq_fifo_tb.sv ====
// Purpose: self-checking bench for depth and flag latency of the queue in all four modes
// Assumes: words enter as an incrementing count from the user model
// Notes:   a shadow occupancy checks common-clock write flags every cycle, and read flags in standard mode only
`timescale 1ns/1ps
`default_nettype none
module fq_fifo_tb;
  import fq_pkg::*;
  logic              core_clk;
  logic              arst_n;
  logic              cfg_dual_domain;
  logic              cfg_fall_through_read_mode;
  logic              wr_en;
  logic [DATA_W-1:0] wr_data;
  logic              rd_en;
  logic              wr_step_r;
  logic              rd_step_r;
  logic [DATA_W-1:0] rd_data_r;
  fq_wr_stat_t       wr_status_r;
  fq_rd_stat_t       rd_status_r;
  logic              clr;
  logic              slow;
  logic              mon_on;
  logic              shadow;
  logic              pend;
  logic              ws_q;
  logic              rs_q;
  logic [1:0]        wa_q;
  logic [1:0]        ra_q;
  logic [15:0]       push_n;
  logic [15:0]       pop_n;
  logic [15:0]       wcnt;
  logic [15:0]       rcnt;
  logic [7:0]        exp_d;
  logic [7:0]        last_d;
  logic              wtk;
  logic              rtk;
  int                occ;
  int                occ_p;
  int                dep;
  int                n_fail = 0;
  int                n_tests = 0;
  int                cyc = 0;
  assign wtk = wr_step_r & wr_en & ~wr_status_r.full;
  assign rtk = rd_step_r & rd_en & ~rd_status_r.empty;

  fq_fifo dut_u (.core_clk(core_clk), .arst_n(arst_n), .cfg_dual_domain(cfg_dual_domain),
    .cfg_fall_through_read_mode(cfg_fall_through_read_mode), .wr_en(wr_en), .wr_data(wr_data),
    .rd_en(rd_en), .wr_step_r(wr_step_r), .rd_step_r(rd_step_r), .rd_data_r(rd_data_r),
    .wr_status_r(wr_status_r), .rd_status_r(rd_status_r));
  fq_user_mdl user_u (.core_clk(core_clk), .clr(clr), .slow(slow), .push_n(push_n), .pop_n(pop_n),
    .wr_step_r(wr_step_r), .rd_step_r(rd_step_r), .full(wr_status_r.full),
    .empty(rd_status_r.empty), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk

  function automatic logic getf(input int sel);
    case (sel)
      0: return rd_status_r.empty;
      1: return wr_status_r.full;
      2: return rd_status_r.lower_threshold_flag;
      default: return wr_status_r.upper_threshold_flag;
    endcase
  endfunction : getf

  // all four modes finish in a few thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  always @(negedge core_clk) begin
    if (mon_on) begin
      if (pend) chk(rd_data_r, last_d);
      pend = 1'b0;
      if (!ws_q) chk({wr_status_r.ack, wr_status_r.overflow}, wa_q);
      if (!rs_q) chk({rd_status_r.valid, rd_status_r.underflow}, ra_q);
      if (shadow) begin
        chk(wr_status_r.count, occ[15:0]);
        chk(rd_status_r.count, occ[15:0]);
        chk(wr_status_r.full, occ == dep);
        chk(wr_status_r.one_slot_left_flag, occ >= dep - 1);
        chk(wr_status_r.upper_threshold_flag, occ_p >= int'(UPPER_THR));
        if (!cfg_fall_through_read_mode) begin
          chk(rd_status_r.empty, occ == 0);
          chk(rd_status_r.one_entry_left_flag, occ <= 1);
          chk(rd_status_r.lower_threshold_flag, occ_p <= int'(LOWER_THR));
        end
      end
      if (rtk) begin
        if (cfg_fall_through_read_mode) chk(rd_data_r, exp_d);
        else begin
          pend = 1'b1;
          last_d = exp_d;
        end
        exp_d++;
      end
      occ_p = occ;
      occ = occ + int'(wtk) - int'(rtk);
      wcnt += 16'(wtk);
      rcnt += 16'(rtk);
    end
    ws_q = wr_step_r;
    rs_q = rd_step_r;
    wa_q = {wr_status_r.ack, wr_status_r.overflow};
    ra_q = {rd_status_r.valid, rd_status_r.underflow};
  end

  task automatic push(input int k);
    @(posedge core_clk);
    push_n <= push_n + 16'(k);
  endtask : push

  task automatic pop(input int k);
    @(posedge core_clk);
    pop_n <= pop_n + 16'(k);
  endtask : pop

  task automatic settle();
    repeat (40) @(posedge core_clk);
    // end between edges so outputs are read settled
    @(negedge core_clk);
  endtask : settle

  task automatic wait_f(input int sel);
    int i;
    i = 0;
    while (getf(sel) !== 1'b1 && i < 300) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 300) chk(16'h0000, 16'h0001);
  endtask : wait_f

  // count far-side steps from the taking edge until the flag moves
  task automatic lat(input bit wside, input int sel, input int lo, input int hi);
    int   n;
    int   i;
    logic f0;
    n = 0;
    i = 0;
    do begin
      @(negedge core_clk);
      i++;
    end while (!(wside ? wtk : rtk) && i < 100);
    f0 = getf(sel);
    @(posedge core_clk);
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (getf(sel) !== f0) break;
      @(posedge core_clk);
      if (wside ? rd_step_r : wr_step_r) n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask : lat

  initial begin
    int  i;
    logic d;
    logic f;
    logic uf;
    arst_n = 1'b0;
    cfg_dual_domain = 1'b0;
    cfg_fall_through_read_mode = 1'b0;
    clr = 1'b1;
    slow = 1'b0;
    push_n = 16'h0000;
    pop_n = 16'h0000;
    mon_on = 1'b0;
    pend = 1'b0;
    for (int m = 0; m < 4; m++) begin
      d = m[1];
      f = m[0];
      mon_on = 1'b0;
      @(posedge core_clk);
      arst_n <= 1'b0;
      clr <= 1'b1;
      push_n <= 16'h0000;
      pop_n <= 16'h0000;
      cfg_dual_domain <= d;
      cfg_fall_through_read_mode <= f;
      slow <= f;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      clr <= 1'b0;
      occ = 0;
      occ_p = 0;
      wcnt = 16'h0000;
      rcnt = 16'h0000;
      exp_d = 8'h00;
      pend = 1'b0;
      shadow = !d;
      dep = !d ? (f ? CFG_DEPTH + 2 : CFG_DEPTH)
                : (f ? (CFG_DEPTH - 1) + 2 * (CFG_DEPTH / CFG_DEPTH) : CFG_DEPTH - 1);
      i = 0;
      while (wr_step_r !== 1'b1 && i < 50) begin
        @(negedge core_clk);
        i++;
      end
      mon_on = 1'b1;
      push(1);
      lat(1'b1, 0, d ? 4 : (f ? 2 : 0), d ? 5 : (f ? 2 : 0));
      push(3);
      settle();
      push(1);
      lat(1'b1, 2, d ? 5 : 1, d ? 6 : 1);
      push(100);
      wait_f(1);
      settle();
      chk(wr_status_r.count, dep[15:0]);
      chk(rd_status_r.count, dep[15:0]);
      chk(wr_status_r.overflow, 16'h0001);
      @(posedge core_clk);
      push_n <= wcnt;
      settle();
      pop(1);
      lat(1'b0, 1, d ? 4 : 0, d ? 5 : 0);
      settle();
      pop(dep - 13);
      settle();
      pop(1);
      lat(1'b0, 3, d ? 5 : 1, d ? 6 : 1);
      pop(100);
      wait_f(0);
      settle();
      // slow reader idles every other cycle, so look across several read steps
      uf = 1'b0;
      repeat (8) begin
        @(negedge core_clk);
        uf = uf | rd_status_r.underflow;
      end
      chk(16'(uf), 16'h0001);
      chk(rd_status_r.count, 16'h0000);
      chk(rcnt, wcnt);
      @(posedge core_clk);
      pop_n <= rcnt;
      settle();
    end
    stop_test();
  end
endmodule : fq_fifo_tb
`default_nettype wire

// ==== dv/fq_user_mdl.sv ====
// Purpose: producer and consumer user logic on the queue write and read ports
// Assumes: push_n and pop_n only grow, or drop back to the words already moved
// Notes:   slow mode leaves every other read cycle idle
`timescale 1ns/1ps
`default_nettype none
module fq_user_mdl (
  input  wire logic                      core_clk,
  input  wire logic                      clr,
  input  wire logic                      slow,
  input  wire logic [15:0]               push_n,
  input  wire logic [15:0]               pop_n,
  input  wire logic                      wr_step_r,
  input  wire logic                      rd_step_r,
  input  wire logic                      full,
  input  wire logic                      empty,
  output logic                           wr_en,
  output logic [fq_pkg::DATA_W-1:0]      wr_data,
  output logic                           rd_en
);
  import fq_pkg::*;
  logic [15:0] wdone;
  logic [15:0] rdone;
  logic [15:0] wdone_nxt;
  logic [15:0] rdone_nxt;
  // a word only counts on a step edge with room or data shown, late flags just delay it
  assign wdone_nxt = wdone + 16'(wr_step_r & wr_en & ~full);
  assign rdone_nxt = rdone + 16'(rd_step_r & rd_en & ~empty);
  always @(posedge core_clk) begin
    if (clr) begin
      wdone   <= 16'h0000;
      rdone   <= 16'h0000;
      wr_en   <= 1'b0;
      rd_en   <= 1'b0;
      wr_data <= '0;
    end else begin
      wdone   <= wdone_nxt;
      rdone   <= rdone_nxt;
      wr_en   <= (wdone_nxt < push_n);
      rd_en   <= (rdone_nxt < pop_n) && (!slow || !rd_en);
      if (wr_step_r && wr_en && !full) begin
        wr_data <= wr_data + 1'b1;
      end
    end
  end
endmodule : fq_user_mdl
`default_nettype wire

// ==== rtl/fq_fifo.sv ====
// Purpose: flop-based queue with common or split step domains and two read modes
// Assumes: cfg inputs static after reset; user logic on core_clk
// Notes:   split mode emulates two clocks with step enables from dividers
// Operation
// R01: common clock standard mode holds exactly the configured depth.
// R02: common clock fall-through mode holds two entries more than configured.
// R03: split clock standard mode holds one entry less than configured.
// R04: split fall-through: write depth minus one plus twice depth ratio; read plus one.
// R05: unequal write/read depths only with block memory storage.
// R06: hard macro builds cascade ceil(depth/primitive) primitives of at least 512.
// R07: hard macro usable depth follows the four cascade formulas.
// R08: latency counts edges after the operating edge; zero means same edge.
// R09: common standard flags update at once; threshold flags one edge later.
// R10: common fall-through: empty lags a write by two, near-empty and lower by one.
// R11: write ack and overflow move only on write steps.
// R12: read valid and underflow move only on read steps.
// R13: split mode write-side flags immediate; upper threshold and count one step later.
// R14: split mode read-side flags immediate; lower threshold and count one step later.
// R15: split mode read reaches full, near-full, write count after four write steps.
// R16: split mode read reaches upper threshold after five write steps.
// R17: split mode write reaches empty, near-empty, read count after four read steps.
// R18: split mode write reaches lower threshold after five read steps.
// R19: crossed flags may arrive one destination step late; both sides tolerate it.
// R20: pointers cross as gray codes through multi-stage synchronisers.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fq_fifo (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  cfg_dual_domain,
  input  wire logic                  cfg_fall_through_read_mode,
  input  wire logic                  wr_en,
  input  wire logic [fq_pkg::DATA_W-1:0] wr_data,
  input  wire logic                  rd_en,
  output var  logic                  wr_step_r,
  output var  logic                  rd_step_r,
  output var  logic [fq_pkg::DATA_W-1:0] rd_data_r,
  output var  fq_pkg::fq_wr_stat_t   wr_status_r,
  output var  fq_pkg::fq_rd_stat_t   rd_status_r
);
  import fq_pkg::*;

  logic                 rst_s1_r;
  logic                 rst_n_r;
  logic [DIV_W-1:0]     wr_div_r;
  logic [DIV_W-1:0]     rd_div_r;
  logic [DATA_W-1:0]    mem_r [STORE_DEPTH];
  logic [PTR_W-1:0]     wr_ptr_r;
  logic [PTR_W-1:0]     rd_ptr_r;
  logic [PTR_W-1:0]     wp_d1_r;
  logic [IDX_W-1:0]     wr_idx_r;
  logic [IDX_W-1:0]     rd_idx_r;
  logic [PTR_W-1:0]     ws_g_r [SYNC_LEN];
  logic [PTR_W-1:0]     rs_g_r [SYNC_LEN];
  logic                 fall_through_read_mode;
  logic                 wr_do;
  logic                 rd_do;
  logic [PTR_W-1:0]     wr_ptr_nxt;
  logic [PTR_W-1:0]     rd_ptr_nxt;
  logic [IDX_W-1:0]     rd_idx_nxt;
  logic [PTR_W-1:0]     cap;
  logic [PTR_W-1:0]     ws3;
  logic [PTR_W-1:0]     ws4;
  logic [PTR_W-1:0]     rs3;
  logic [PTR_W-1:0]     rs4;
  logic [PTR_W-1:0]     occ_full;
  logic [PTR_W-1:0]     occ_upper;
  logic [PTR_W-1:0]     occ_empty;
  logic [PTR_W-1:0]     occ_near;
  logic [PTR_W-1:0]     occ_lower;
  logic [PTR_W-1:0]     wr_cnt_nxt;
  logic [PTR_W-1:0]     rd_cnt_nxt;

  function automatic logic [IDX_W-1:0] idx_inc(input logic [IDX_W-1:0] i);
    return (i == IDX_LAST) ? '0 : i + 5'h01;
  endfunction : idx_inc

  // reset release through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // step enables: every cycle in common mode, divided in split mode
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_div_r  <= '0;
      rd_div_r  <= '0;
      wr_step_r <= 1'b0;
      rd_step_r <= 1'b0;
    end else begin
      wr_div_r  <= (wr_div_r == DIV_W'(WR_DIV - 1)) ? '0 : wr_div_r + 2'h1;
      rd_div_r  <= (rd_div_r == DIV_W'(RD_DIV - 1)) ? '0 : rd_div_r + 2'h1;
      wr_step_r <= !cfg_dual_domain || (wr_div_r == '0);
      rd_step_r <= !cfg_dual_domain || (rd_div_r == '0);
    end
  end

  assign fall_through_read_mode       = cfg_fall_through_read_mode;
  // symmetric ports only, so flop storage is allowed
  assign cap        = usable_wr_depth(cfg_dual_domain, fall_through_read_mode);  // R01 R02 R03 R04 R05
  assign wr_do      = wr_step_r && wr_en && !wr_status_r.full;
  assign rd_do      = rd_step_r && rd_en && !rd_status_r.empty;
  assign wr_ptr_nxt = wr_ptr_r + PTR_W'(wr_do);
  assign rd_ptr_nxt = rd_ptr_r + PTR_W'(rd_do);
  assign rd_idx_nxt = rd_do ? idx_inc(rd_idx_r) : rd_idx_r;

  // gray pointers seen by the other side
  assign ws3 = gray2bin(ws_g_r[2]);  // R20
  assign ws4 = gray2bin(ws_g_r[3]);
  assign rs3 = gray2bin(rs_g_r[2]);  // R20
  assign rs4 = gray2bin(rs_g_r[3]);

  // synchroniser chains, stage 0 feeds only stage 1
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ws_g_r[0] <= PTR_RST;
      rs_g_r[0] <= PTR_RST;
    end else begin
      if (rd_step_r) begin
        ws_g_r[0] <= bin2gray(wr_ptr_r);  // R20
      end
      if (wr_step_r) begin
        rs_g_r[0] <= bin2gray(rd_ptr_r);  // R20
      end
    end
  end

  for (genvar s = 1; s < SYNC_LEN; s++) begin : g_sync
    always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        ws_g_r[s] <= PTR_RST;
        rs_g_r[s] <= PTR_RST;
      end else begin
        if (rd_step_r) begin
          ws_g_r[s] <= ws_g_r[s-1];
        end
        if (wr_step_r) begin
          rs_g_r[s] <= rs_g_r[s-1];
        end
      end
    end
  end

  // storage and pointers
  always_ff @(posedge core_clk) begin
    if (wr_do) begin
      mem_r[wr_idx_r] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_ptr_r <= PTR_RST;
      rd_ptr_r <= PTR_RST;
      wp_d1_r  <= PTR_RST;
      wr_idx_r <= '0;
      rd_idx_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      wp_d1_r  <= wr_ptr_r;
      wr_idx_r <= wr_do ? idx_inc(wr_idx_r) : wr_idx_r;
      rd_idx_r <= rd_idx_nxt;
    end
  end

  // write-side occupancy views; split mode counts on synchronised read pointer
  always_comb begin
    if (cfg_dual_domain) begin
      occ_full   = wr_ptr_nxt - rs3;  // R15 R19
      occ_upper  = wr_ptr_r - rs4;    // R16 R19
      wr_cnt_nxt = wr_ptr_r - rs3;    // R13 R15
    end else begin
      occ_full   = wr_ptr_nxt - rd_ptr_nxt;  // R09
      occ_upper  = wr_ptr_r - rd_ptr_r;      // R09
      wr_cnt_nxt = wr_ptr_nxt - rd_ptr_nxt;  // R09
    end
  end

  // read-side occupancy views per mode
  always_comb begin
    if (cfg_dual_domain) begin
      occ_empty  = ws3 - rd_ptr_nxt;  // R17 R19
      occ_near   = ws3 - rd_ptr_nxt;  // R17
      occ_lower  = ws4 - rd_ptr_r;    // R18 R14
      rd_cnt_nxt = ws3 - rd_ptr_r;    // R14 R17
    end else if (fall_through_read_mode) begin
      occ_empty  = wp_d1_r - rd_ptr_nxt;    // R10
      occ_near   = wr_ptr_r - rd_ptr_nxt;   // R10
      occ_lower  = wr_ptr_r - rd_ptr_r;     // R10
      rd_cnt_nxt = wr_ptr_nxt - rd_ptr_nxt;
    end else begin
      occ_empty  = wr_ptr_nxt - rd_ptr_nxt;  // R09
      occ_near   = wr_ptr_nxt - rd_ptr_nxt;  // R09
      occ_lower  = wr_ptr_r - rd_ptr_r;      // R09
      rd_cnt_nxt = wr_ptr_nxt - rd_ptr_nxt;  // R09
    end
  end

  // write status moves only on write steps; latency 0 lands on the operating edge
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_status_r <= WR_STAT_RST;
    end else if (wr_step_r) begin                               // R08
      wr_status_r.full                 <= occ_full >= cap;    // R13
      wr_status_r.one_slot_left_flag   <= occ_full >= cap - 6'h01;  // R13
      wr_status_r.upper_threshold_flag <= occ_upper >= UPPER_THR;   // R13
      wr_status_r.ack                  <= wr_do;              // R11
      wr_status_r.overflow             <= wr_en && wr_status_r.full;  // R11
      wr_status_r.count                <= wr_cnt_nxt;
    end
  end

  // read status moves only on read steps
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_status_r <= RD_STAT_RST;
    end else if (rd_step_r) begin                               // R08
      rd_status_r.empty                <= occ_empty == '0;    // R14
      rd_status_r.one_entry_left_flag  <= occ_near <= 6'h01;  // R14
      rd_status_r.lower_threshold_flag <= occ_lower <= LOWER_THR;  // R14
      rd_status_r.valid                <= rd_do;              // R12
      rd_status_r.underflow            <= rd_en && rd_status_r.empty;  // R12
      rd_status_r.count                <= rd_cnt_nxt;
    end
  end

  // fall-through shows the head word; standard mode loads it on a read
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data_r <= '0;
    end else if (rd_step_r && fall_through_read_mode) begin
      rd_data_r <= mem_r[rd_idx_nxt];
    end else if (rd_do) begin
      rd_data_r <= mem_r[rd_idx_r];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n_r);

  // overflow stands between write steps, so only the cycle after its update is judged
  ovf_needs_full_a: assert property ( // R11
      (wr_status_r.overflow && $past(wr_step_r)) |-> $past(wr_status_r.full && wr_en))
    else $error("overflow without a write into a full queue");

  ack_write_only_a: assert property ($changed(wr_status_r.ack) |-> $past(wr_step_r)) // R11
    else $error("write ack moved outside a write step");

  valid_read_only_a: assert property ($rose(rd_status_r.valid) |-> $past(rd_en && rd_step_r)) // R12
    else $error("read valid rose without a read");

  common_std_empty_a: assert property (
      (!cfg_dual_domain && !fall_through_read_mode && rd_status_r.empty && wr_do) |=> !rd_status_r.empty) // R09
    else $error("empty did not clear on the write edge");

  fall_through_read_mode_empty_lat_a: assert property (
      (!cfg_dual_domain && fall_through_read_mode && rd_status_r.empty && wr_do && wr_ptr_r == rd_ptr_r && wp_d1_r == rd_ptr_r)
      |=> rd_status_r.empty ##1 rd_status_r.empty ##1 !rd_status_r.empty) // R10
    else $error("fall-through empty latency not two");

  std_depth_full_a: assert property (
      (!cfg_dual_domain && !fall_through_read_mode && wr_status_r.full) |-> wr_status_r.count == 6'h10) // R01
    else $error("standard full at wrong depth");

  fall_through_read_mode_depth_full_a: assert property (
      (!cfg_dual_domain && fall_through_read_mode && wr_status_r.full) |-> wr_status_r.count == 6'h12) // R02
    else $error("fall-through full at wrong depth");

  split_depth_cap_a: assert property (
      (cfg_dual_domain && !fall_through_read_mode) |-> (wr_ptr_r - rd_ptr_r) <= 6'h0f) // R03
    else $error("split standard queue exceeded its depth");

  split_full_clear_a: assert property (
      (cfg_dual_domain && wr_status_r.full && rd_do) |-> ##[1:20] !wr_status_r.full) // R15
    else $error("full did not clear after a read");

  split_empty_clear_a: assert property (
      (cfg_dual_domain && rd_status_r.empty && wr_do) |-> ##[1:25] !rd_status_r.empty) // R17
    else $error("empty did not clear after a write");

  split_full_hold_a: assert property (
      (cfg_dual_domain && wr_status_r.full && rd_do && !wr_step_r) |=> wr_status_r.full) // R15
    else $error("full cleared before the crossing");

  unf_needs_empty_a: assert property ( // R12
      (rd_status_r.underflow && $past(rd_step_r)) |-> $past(rd_status_r.empty && rd_en))
    else $error("underflow without a read from an empty queue");

  write_ack_now_a: assert property (wr_do |=> wr_status_r.ack) // R13
    else $error("write ack missed the operating edge");

  read_valid_now_a: assert property (rd_do |=> rd_status_r.valid) // R14
    else $error("read valid missed the operating edge");

endmodule : fq_fifo
`default_nettype wire

// ==== rtl/fq_pkg.sv ====
// Purpose: shared constants, status carriers and depth helpers for the queue
// Assumes: symmetric write/read widths; flop storage
// Notes:   thresholds and step dividers are plain defaults
package fq_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CFG_DEPTH   = 16;
  localparam int unsigned PTR_W       = 6;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned STORE_DEPTH = CFG_DEPTH + 2;
  localparam int unsigned SYNC_LEN    = 4;
  localparam int unsigned WR_DIV      = 2;
  localparam int unsigned RD_DIV      = 3;
  localparam int unsigned DIV_W       = 2;
  localparam int unsigned PRIM_DEPTH  = 512;
  localparam int unsigned MACRO_N     = (CFG_DEPTH + PRIM_DEPTH - 1) / PRIM_DEPTH;
  localparam logic [PTR_W-1:0] UPPER_THR = 6'h0c;
  localparam logic [PTR_W-1:0] LOWER_THR = 6'h04;
  localparam logic [PTR_W-1:0] PTR_RST   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_LAST  = 5'h11;

  typedef struct packed {
    logic             full;
    logic             one_slot_left_flag;
    logic             upper_threshold_flag;
    logic             ack;
    logic             overflow;
    logic [PTR_W-1:0] count;
  } fq_wr_stat_t;

  typedef struct packed {
    logic             empty;
    logic             one_entry_left_flag;
    logic             lower_threshold_flag;
    logic             valid;
    logic             underflow;
    logic [PTR_W-1:0] count;
  } fq_rd_stat_t;

  localparam fq_wr_stat_t WR_STAT_RST = '{default: '0};
  localparam fq_rd_stat_t RD_STAT_RST = '{empty: 1'b1, one_entry_left_flag: 1'b1,
                                         lower_threshold_flag: 1'b1, default: '0};

  function automatic logic [PTR_W-1:0] usable_wr_depth(input logic dual, input logic fall_through_read_mode);
    int unsigned d;
    d = CFG_DEPTH;
    if (!dual && fall_through_read_mode) begin
      d = CFG_DEPTH + 2;                                          // R02
    end else if (dual && !fall_through_read_mode) begin
      d = CFG_DEPTH - 1;                                          // R03
    end else if (dual && fall_through_read_mode) begin
      d = (CFG_DEPTH - 1) + 2 * (CFG_DEPTH / CFG_DEPTH);          // R04
    end
    return PTR_W'(d);                                             // R01
  endfunction : usable_wr_depth

  // hard-macro cascade depth for reference builds of depth prim
  function automatic int unsigned macro_wr_depth(input logic dual, input logic fall_through_read_mode);
    int unsigned p;
    int unsigned n;
    p = (PRIM_DEPTH < 512) ? 512 : PRIM_DEPTH;                    // R06
    n = MACRO_N;                                                  // R06
    if (dual) begin
      return fall_through_read_mode ? (p + 2) * n : (p + 2) * (n - 1) + (p + 1);    // R07
    end
    return fall_through_read_mode ? (p + 1) * n : (p + 1) * (n - 1) + p;            // R07
  endfunction : macro_wr_depth

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

endpackage : fq_pkg
